// File: design/dbs_pkg.sv
`default_nettype none
package dbs_pkg;
    localparam int          AV_ADDR_W      = 9;
    localparam int          AV_DATA_W      = 32;
    localparam int          AV_BE_W        = 4;
    localparam int          REG_W          = 8;
    localparam int          CODE_W         = 6;
    localparam int          LEVEL_W        = 7;
    localparam int          CHANS          = 2;
    localparam int          BYTE_SHIFT     = 2;
    localparam int          RANGE_BIT      = 6;
    // register indices; byte address is four times the index
    localparam logic [6:0]  IDX_A_NORMAL   = 7'h3c;
    localparam logic [6:0]  IDX_A_STANDBY  = 7'h3d;
    localparam logic [6:0]  IDX_A_SLEEP    = 7'h3e;
    localparam logic [6:0]  IDX_A_MODE     = 7'h3f;
    localparam logic [6:0]  IDX_A_CONFIG   = 7'h40;
    localparam logic [6:0]  IDX_B_NORMAL   = 7'h43;
    localparam logic [6:0]  IDX_B_STANDBY  = 7'h44;
    localparam logic [6:0]  IDX_B_SLEEP    = 7'h45;
    localparam logic [6:0]  IDX_B_MODE     = 7'h46;
    localparam logic [6:0]  IDX_B_CONFIG   = 7'h47;
    localparam logic [6:0]  IDX_STATUS     = 7'h48;
    // set-point selectors inside one channel
    localparam logic [1:0]  SP_NORMAL      = 2'h0;
    localparam logic [1:0]  SP_STANDBY     = 2'h1;
    localparam logic [1:0]  SP_SLEEP       = 2'h2;
    localparam logic [7:0]  RST_SETPOINT   = 8'h00;
    localparam logic [7:0]  RST_MODE       = 8'h00;
    localparam logic [7:0]  RST_CONFIG     = 8'h00;
    localparam logic [7:0]  MODE_WR_MASK   = 8'h2f;
    localparam logic [7:0]  CONF_WR_MASK   = 8'hff;
    // mode fields
    localparam int          MODE_SW_LSB    = 0;
    localparam int          MODE_SW_W      = 4;
    localparam int          MODE_PFM_BIT   = 5;
    // config fields
    localparam int          CONF_CURRENT_LIMIT_SELECT_BIT  = 0;
    localparam int          CONF_FREQ_LSB  = 2;
    localparam int          CONF_PHASE_LSB = 4;
    localparam int          CONF_RAMP_LSB  = 6;
    localparam int          CONF_FLD_W     = 2;
    // status fields
    localparam int          STAT_PWR_LSB   = 0;
    localparam int          STAT_PHASE_BIT = 2;
    localparam int          STAT_RANGE_LSB = 3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        DBS_PWR_NORMAL,
        DBS_PWR_STANDBY,
        DBS_PWR_SLEEP
    } dbs_pwr_e;

    typedef enum logic {
        DBS_BUS_IDLE,
        DBS_BUS_ANSWER
    } dbs_bus_e;
endpackage : dbs_pkg
`default_nettype wire

// File: design/dbs_sp_if.sv
`default_nettype none
interface dbs_sp_if;
    logic       wr;
    logic [1:0] sel;
    logic [5:0] code;
    logic       range_load;
    logic       range_val;
    logic [7:0] rd_normal;
    logic [7:0] rd_standby;
    logic [7:0] rd_sleep;

    modport ctrl (
        output wr, sel, code, range_load, range_val,
        input  rd_normal, rd_standby, rd_sleep
    );
    modport bank (
        input  wr, sel, code, range_load, range_val,
        output rd_normal, rd_standby, rd_sleep
    );
endinterface : dbs_sp_if
`default_nettype wire

// File: design/dbs_chan_bank.sv
`default_nettype none
module dbs_chan_bank (
    input  wire logic clk_in,
    input  wire logic rst_in,
    dbs_sp_if.bank    bus
);
    import dbs_pkg::*;

    logic [CODE_W-1:0] normal_reg;
    logic [CODE_W-1:0] standby_reg;
    logic [CODE_W-1:0] sleep_reg;
    logic              range_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            normal_reg  <= RST_SETPOINT[CODE_W-1:0];
            standby_reg <= RST_SETPOINT[CODE_W-1:0];
            sleep_reg   <= RST_SETPOINT[CODE_W-1:0];
        end else if (bus.wr) begin
            case (bus.sel)
                SP_NORMAL:  normal_reg  <= bus.code;
                SP_STANDBY: standby_reg <= bus.code;
                SP_SLEEP:   sleep_reg   <= bus.code;
                default: ;
            endcase
        end
    end

    // range only moves on a configuration load, never on a bus write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            range_reg <= RST_SETPOINT[RANGE_BIT];
        end else if (bus.range_load) begin
            range_reg <= bus.range_val;
        end
    end

    assign bus.rd_normal  = {1'b0, range_reg, normal_reg};
    assign bus.rd_standby = {1'b0, range_reg, standby_reg};
    assign bus.rd_sleep   = {1'b0, range_reg, sleep_reg};
endmodule : dbs_chan_bank
`default_nettype wire

// File: design/dbs_level_sel.sv
`default_nettype none
module dbs_level_sel (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire dbs_pkg::dbs_pwr_e       pwr_state_in,
    input  wire logic [7:0]              normal_in,
    input  wire logic [7:0]              standby_in,
    input  wire logic [7:0]              sleep_in,
    output logic [dbs_pkg::LEVEL_W-1:0]  level_out
);
    import dbs_pkg::*;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_out <= RST_SETPOINT[LEVEL_W-1:0];
        end else begin
            case (pwr_state_in)
                DBS_PWR_NORMAL:  level_out <= normal_in[LEVEL_W-1:0];
                DBS_PWR_STANDBY: level_out <= standby_in[LEVEL_W-1:0];
                DBS_PWR_SLEEP:   level_out <= sleep_in[LEVEL_W-1:0];
                default:         level_out <= normal_in[LEVEL_W-1:0];
            endcase
        end
    end
endmodule : dbs_level_sel
`default_nettype wire

// File: design/dbs_regs.sv
// Operation
// - The channel A normal set-point holds a writable 6-bit code in bits 5:0 that sets the normal-state level.
// - The channel A standby set-point holds a writable 6-bit code applied in the standby state.
// - The channel A sleep set-point holds a writable 6-bit code applied in the sleep state.
// - Bit 6 of each normal set-point is a read-only range bit loaded only by configuration.
// - Bit 6 of standby and sleep set-points reads back the same channel's normal range bit.
// - Channel B normal, standby and sleep set-points sit at consecutive addresses with channel A's layout.
// - Each channel has a switching-mode register directly after its sleep set-point.
// - Each channel has a configuration register with ramp speed, phase, frequency and current limit.
// - All three channel A set-points reset to zero in every field.
//
// Added by the designer: the Avalon-MM register port.
`default_nettype none
module dbs_regs (
    input  wire logic                         core_clk_in,
    input  wire logic                         rst_in,
    input  wire logic [dbs_pkg::AV_ADDR_W-1:0] avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [dbs_pkg::AV_DATA_W-1:0] avs_writedata_in,
    input  wire logic [dbs_pkg::AV_BE_W-1:0]  avs_byteenable_in,
    output logic [dbs_pkg::AV_DATA_W-1:0]     avs_readdata_out,
    output logic                              avs_waitrequest_out,
    output logic [1:0]                        avs_response_out,
    input  wire logic                         cfg_load_in,
    input  wire logic                         cfg_range_a_in,
    input  wire logic                         cfg_range_b_in,
    input  wire dbs_pkg::dbs_pwr_e            pwr_state_in,
    input  wire logic                         single_phase_in,
    output logic [dbs_pkg::LEVEL_W-1:0]       chan_a_level_out,
    output logic [dbs_pkg::LEVEL_W-1:0]       chan_b_level_out,
    output logic [3:0]                        chan_a_switch_mode_out,
    output logic [3:0]                        chan_b_switch_mode_out,
    output logic                              chan_a_sleep_pfm_out,
    output logic                              chan_b_sleep_pfm_out,
    output logic                              chan_a_current_limit_out,
    output logic                              chan_b_current_limit_out,
    output logic [1:0]                        chan_a_freq_out,
    output logic [1:0]                        chan_b_freq_out,
    output logic [1:0]                        chan_a_phase_out,
    output logic [1:0]                        chan_b_phase_out,
    output logic [1:0]                        chan_a_ramp_speed_out,
    output logic [1:0]                        chan_b_ramp_speed_out
);
    import dbs_pkg::*;

    dbs_bus_e               bus_state_reg;
    logic                   wait_reg;
    logic [AV_DATA_W-1:0]   rdata_reg;
    logic [1:0]             resp_reg;

    logic [6:0]             reg_idx;
    logic                   aligned;
    logic                   hit;
    logic                   wr_fire;
    logic [REG_W-1:0]       rd_mux;
    logic [REG_W-1:0]       wbyte;

    logic [REG_W-1:0]       mode_reg   [CHANS];
    logic [REG_W-1:0]       config_reg [CHANS];
    logic [REG_W-1:0]       sp_rd      [CHANS][3];
    logic [CHANS-1:0]       sp_wr;
    logic [1:0]             sp_sel;
    logic [CHANS-1:0]       mode_wr;
    logic [CHANS-1:0]       config_wr;
    logic [CHANS-1:0]       cfg_range;

    logic [REG_W-1:0]       eff_mode_reg   [CHANS];
    logic [REG_W-1:0]       eff_config_reg [CHANS];
    logic [REG_W-1:0]       b_src [3];

    assign reg_idx = avs_address_in[AV_ADDR_W-1:BYTE_SHIFT];
    assign aligned = (avs_address_in[BYTE_SHIFT-1:0] == '0);
    assign wbyte   = avs_writedata_in[REG_W-1:0];
    assign cfg_range = {cfg_range_b_in, cfg_range_a_in};

    // address decode; channel B block mirrors channel A's layout
    always_comb begin
        hit    = 1'b0;
        sp_wr  = '0;
        sp_sel = SP_NORMAL;
        mode_wr   = '0;
        config_wr = '0;
        if (aligned) begin
            case (reg_idx)
                IDX_A_NORMAL: begin
                    hit      = 1'b1;
                    sp_wr[0] = 1'b1;
                    sp_sel   = SP_NORMAL;
                end
                IDX_A_STANDBY: begin
                    hit      = 1'b1;
                    sp_wr[0] = 1'b1;
                    sp_sel   = SP_STANDBY;
                end
                IDX_A_SLEEP: begin
                    hit      = 1'b1;
                    sp_wr[0] = 1'b1;
                    sp_sel   = SP_SLEEP;
                end
                IDX_A_MODE: begin
                    hit        = 1'b1;
                    mode_wr[0] = 1'b1;
                end
                IDX_A_CONFIG: begin
                    hit          = 1'b1;
                    config_wr[0] = 1'b1;
                end
                IDX_B_NORMAL: begin
                    hit      = 1'b1;
                    sp_wr[1] = 1'b1;
                    sp_sel   = SP_NORMAL;
                end
                IDX_B_STANDBY: begin
                    hit      = 1'b1;
                    sp_wr[1] = 1'b1;
                    sp_sel   = SP_STANDBY;
                end
                IDX_B_SLEEP: begin
                    hit      = 1'b1;
                    sp_wr[1] = 1'b1;
                    sp_sel   = SP_SLEEP;
                end
                IDX_B_MODE: begin
                    hit        = 1'b1;
                    mode_wr[1] = 1'b1;
                end
                IDX_B_CONFIG: begin
                    hit          = 1'b1;
                    config_wr[1] = 1'b1;
                end
                IDX_STATUS: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rd_mux = '0;
        if (aligned) begin
            case (reg_idx)
                IDX_A_NORMAL:  rd_mux = sp_rd[0][SP_NORMAL];
                IDX_A_STANDBY: rd_mux = sp_rd[0][SP_STANDBY];
                IDX_A_SLEEP:   rd_mux = sp_rd[0][SP_SLEEP];
                IDX_A_MODE:    rd_mux = mode_reg[0];
                IDX_A_CONFIG:  rd_mux = config_reg[0];
                IDX_B_NORMAL:  rd_mux = sp_rd[1][SP_NORMAL];
                IDX_B_STANDBY: rd_mux = sp_rd[1][SP_STANDBY];
                IDX_B_SLEEP:   rd_mux = sp_rd[1][SP_SLEEP];
                IDX_B_MODE:    rd_mux = mode_reg[1];
                IDX_B_CONFIG:  rd_mux = config_reg[1];
                IDX_STATUS: begin
                    rd_mux[STAT_PWR_LSB +: 2] = pwr_state_in;
                    rd_mux[STAT_PHASE_BIT]    = single_phase_in;
                    rd_mux[STAT_RANGE_LSB]    = sp_rd[0][SP_NORMAL][RANGE_BIT];
                    rd_mux[STAT_RANGE_LSB+1]  = sp_rd[1][SP_NORMAL][RANGE_BIT];
                end
                default: rd_mux = '0;
            endcase
        end
    end

    // two-edge answer: request seen, then waitrequest drops for one cycle;
    // the write lands on the edge where the master sees waitrequest low
    assign wr_fire = (bus_state_reg == DBS_BUS_ANSWER) && avs_write_in
                     && hit && avs_byteenable_in[0];

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_state_reg <= DBS_BUS_IDLE;
            wait_reg      <= 1'b1;
            rdata_reg     <= '0;
            resp_reg      <= RESP_OKAY;
        end else begin
            case (bus_state_reg)
                DBS_BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_state_reg <= DBS_BUS_ANSWER;
                        wait_reg      <= 1'b0;
                        rdata_reg     <= avs_read_in ?
                            {{(AV_DATA_W-REG_W){1'b0}}, rd_mux} : '0;
                        resp_reg      <= hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                DBS_BUS_ANSWER: begin
                    bus_state_reg <= DBS_BUS_IDLE;
                    wait_reg      <= 1'b1;
                end
                default: begin
                    bus_state_reg <= DBS_BUS_IDLE;
                    wait_reg      <= 1'b1;
                end
            endcase
        end
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign avs_response_out    = resp_reg;

    // unused mode bits masked so they read back as zero
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < CHANS; i++) begin
                mode_reg[i]   <= RST_MODE;
                config_reg[i] <= RST_CONFIG;
            end
        end else begin
            for (int i = 0; i < CHANS; i++) begin
                if (wr_fire && mode_wr[i]) begin
                    mode_reg[i] <= wbyte & MODE_WR_MASK;
                end
                if (wr_fire && config_wr[i]) begin
                    config_reg[i] <= wbyte & CONF_WR_MASK;
                end
            end
        end
    end

    // combined output: channel A's registers steer both phases
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < CHANS; i++) begin
                eff_mode_reg[i]   <= RST_MODE;
                eff_config_reg[i] <= RST_CONFIG;
            end
        end else begin
            eff_mode_reg[0]   <= mode_reg[0];
            eff_config_reg[0] <= config_reg[0];
            eff_mode_reg[1]   <= single_phase_in ? mode_reg[0] : mode_reg[1];
            eff_config_reg[1] <= single_phase_in ? config_reg[0]
                                                 : config_reg[1];
        end
    end

    assign chan_a_switch_mode_out   = eff_mode_reg[0][MODE_SW_LSB +: MODE_SW_W];
    assign chan_b_switch_mode_out   = eff_mode_reg[1][MODE_SW_LSB +: MODE_SW_W];
    assign chan_a_sleep_pfm_out     = eff_mode_reg[0][MODE_PFM_BIT];
    assign chan_b_sleep_pfm_out     = eff_mode_reg[1][MODE_PFM_BIT];
    assign chan_a_current_limit_out = eff_config_reg[0][CONF_CURRENT_LIMIT_SELECT_BIT];
    assign chan_b_current_limit_out = eff_config_reg[1][CONF_CURRENT_LIMIT_SELECT_BIT];
    assign chan_a_freq_out  = eff_config_reg[0][CONF_FREQ_LSB +: CONF_FLD_W];
    assign chan_b_freq_out  = eff_config_reg[1][CONF_FREQ_LSB +: CONF_FLD_W];
    assign chan_a_phase_out = eff_config_reg[0][CONF_PHASE_LSB +: CONF_FLD_W];
    assign chan_b_phase_out = eff_config_reg[1][CONF_PHASE_LSB +: CONF_FLD_W];
    assign chan_a_ramp_speed_out =
        eff_config_reg[0][CONF_RAMP_LSB +: CONF_FLD_W];
    assign chan_b_ramp_speed_out =
        eff_config_reg[1][CONF_RAMP_LSB +: CONF_FLD_W];

    dbs_sp_if sp_if [CHANS] ();

    genvar g;
    generate
        for (g = 0; g < CHANS; g++) begin : g_chan
            // only bits 5:0 travel; bits 7:6 of the write are dropped
            assign sp_if[g].wr         = wr_fire && sp_wr[g];
            assign sp_if[g].sel        = sp_sel;
            assign sp_if[g].code       = wbyte[CODE_W-1:0];
            assign sp_if[g].range_load = cfg_load_in;
            assign sp_if[g].range_val  = cfg_range[g];
            assign sp_rd[g][SP_NORMAL]  = sp_if[g].rd_normal;
            assign sp_rd[g][SP_STANDBY] = sp_if[g].rd_standby;
            assign sp_rd[g][SP_SLEEP]   = sp_if[g].rd_sleep;

            dbs_chan_bank u_bank (
                .clk_in (core_clk_in),
                .rst_in (rst_in),
                .bus    (sp_if[g].bank)
            );
        end
    endgenerate

    // reserved high codes are passed through untouched; no clamp
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            b_src[k] = single_phase_in ? sp_rd[0][k] : sp_rd[1][k];
        end
    end

    dbs_level_sel u_sel_a (
        .clk_in       (core_clk_in),
        .rst_in       (rst_in),
        .pwr_state_in (pwr_state_in),
        .normal_in    (sp_rd[0][SP_NORMAL]),
        .standby_in   (sp_rd[0][SP_STANDBY]),
        .sleep_in     (sp_rd[0][SP_SLEEP]),
        .level_out    (chan_a_level_out)
    );

    dbs_level_sel u_sel_b (
        .clk_in       (core_clk_in),
        .rst_in       (rst_in),
        .pwr_state_in (pwr_state_in),
        .normal_in    (b_src[SP_NORMAL]),
        .standby_in   (b_src[SP_STANDBY]),
        .sleep_in     (b_src[SP_SLEEP]),
        .level_out    (chan_b_level_out)
    );
endmodule : dbs_regs
`default_nettype wire

// File: verif/dbs_regs_assertions.sv
`default_nettype none
module dbs_regs_checker (
    input wire logic                          core_clk_in,
    input wire logic                          rst_in,
    input wire logic [dbs_pkg::AV_ADDR_W-1:0] avs_address_in,
    input wire logic                          avs_read_in,
    input wire logic                          avs_write_in,
    input wire logic [dbs_pkg::AV_DATA_W-1:0] avs_readdata_out,
    input wire logic                          avs_waitrequest_out,
    input wire logic [1:0]                    avs_response_out,
    input wire logic                          cfg_load_in,
    input wire logic                          cfg_range_a_in,
    input wire logic                          cfg_range_b_in,
    input wire logic                          single_phase_in,
    input wire logic [dbs_pkg::LEVEL_W-1:0]   chan_a_level_out,
    input wire logic [dbs_pkg::LEVEL_W-1:0]   chan_b_level_out
);
    import dbs_pkg::*;
    logic [6:0] idx;
    logic       algn, mapped, spt, ans, rd_ans;
    assign idx = avs_address_in[8:2];
    assign algn = avs_address_in[1:0] == 2'h0;
    assign spt = algn && (idx inside {[IDX_A_NORMAL:IDX_A_SLEEP],
                                      [IDX_B_NORMAL:IDX_B_SLEEP]});
    assign mapped = algn && (idx inside {[IDX_A_NORMAL:IDX_A_CONFIG],
                                         [IDX_B_NORMAL:IDX_STATUS]});
    assign ans = !avs_waitrequest_out && (avs_read_in || avs_write_in);
    assign rd_ans = ans && avs_read_in;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    AST_ANSWER_NEXT: assert property ($rose(avs_read_in || avs_write_in)
        |=> !avs_waitrequest_out) else $error("request not answered");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_out
        |=> avs_waitrequest_out) else $error("waitrequest low too long");
    AST_UNMAPPED: assert property (ans && !mapped
        |-> avs_response_out == RESP_SLVERR) else $error("unmapped not refused");
    AST_UPPER_ZERO: assert property (rd_ans |-> avs_readdata_out[31:8] == 0
        && !(spt && avs_readdata_out[7])) else $error("unused bits not zero");
    AST_MODE_RSVD: assert property (rd_ans && algn
        && (idx == IDX_A_MODE || idx == IDX_B_MODE)
        |-> (avs_readdata_out[7:0] & ~MODE_WR_MASK) == 8'h00)
        else $error("mode reserved bits set");
    AST_SP_RANGE: assert property (rd_ans && spt && idx <= IDX_A_SLEEP
        && !cfg_load_in && !$past(cfg_load_in) && !$past(cfg_load_in, 2)
        |-> avs_readdata_out[6] == chan_a_level_out[6])
        else $error("range bit readback differs");
    AST_RANGE_A: assert property (cfg_load_in |-> ##2
        chan_a_level_out[6] == $past(cfg_range_a_in, 2))
        else $error("range a not loaded");
    AST_RANGE_B: assert property (cfg_load_in ##1 !single_phase_in |=>
        chan_b_level_out[6] == $past(cfg_range_b_in, 2))
        else $error("range b not loaded");
    AST_RESET_ZERO: assert property ($fell(rst_in) |->
        chan_a_level_out == 7'h00 && chan_b_level_out == 7'h00)
        else $error("levels not zero after reset");
endmodule : dbs_regs_checker

bind dbs_regs dbs_regs_checker u_checker (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .cfg_load_in(cfg_load_in),
    .cfg_range_a_in(cfg_range_a_in), .cfg_range_b_in(cfg_range_b_in),
    .single_phase_in(single_phase_in),
    .chan_a_level_out(chan_a_level_out), .chan_b_level_out(chan_b_level_out));
`default_nettype wire

// File: verif/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dbs_pkg::*;
    logic        clk = 1'b0;
    logic        rst, rd, wr, load, rng_a, rng_b, single, waitreq;
    logic [8:0]  addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  be, mode_a, mode_b;
    logic [1:0]  resp, ramp_a, ramp_b, freq_a, freq_b, ph_a, ph_b;
    logic        pfm_a, pfm_b, current_limit_select_a, current_limit_select_b;
    dbs_pwr_e    pwr;
    logic [6:0]  lvl_a, lvl_b;
    logic [10:0] note;
    logic [10:0] notes[$];
    logic [7:0]  code[6];
    logic [7:0]  cfg;
    logic [6:0]  sp[6] = '{IDX_A_NORMAL, IDX_A_STANDBY, IDX_A_SLEEP,
                           IDX_B_NORMAL, IDX_B_STANDBY, IDX_B_SLEEP};
    logic [6:0]  oth[4] = '{IDX_A_MODE, IDX_A_CONFIG, IDX_B_MODE, IDX_B_CONFIG};
    int          bad_count = 0, checks = 0, cycles = 0, seed = 63;

    always #5 clk = ~clk;

    dbs_regs dut (.core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .avs_response_out(resp),
        .cfg_load_in(load), .cfg_range_a_in(rng_a), .cfg_range_b_in(rng_b),
        .pwr_state_in(pwr), .single_phase_in(single),
        .chan_a_level_out(lvl_a), .chan_b_level_out(lvl_b),
        .chan_a_switch_mode_out(mode_a), .chan_b_switch_mode_out(mode_b),
        .chan_a_sleep_pfm_out(pfm_a), .chan_b_sleep_pfm_out(pfm_b),
        .chan_a_current_limit_out(current_limit_select_a), .chan_b_current_limit_out(current_limit_select_b),
        .chan_a_freq_out(freq_a), .chan_b_freq_out(freq_b),
        .chan_a_phase_out(ph_a), .chan_b_phase_out(ph_b),
        .chan_a_ramp_speed_out(ramp_a), .chan_b_ramp_speed_out(ramp_b));

    task automatic conclude();
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    // request held until the edge that sees waitrequest low
    task automatic xfer(input logic r, input logic [8:0] a,
                        input logic [7:0] d, input logic [3:0] e,
                        input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = $random(seed);
        notes.push_back({r, ed, er});
        @(posedge clk);
        rd <= r;
        wr <= !r;
        addr <= a;
        be <= e;
        wdata <= {n[31:8], d};
        do @(posedge clk); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : xfer

    task automatic put(input logic [6:0] i, input logic [7:0] d);
        xfer(1'b0, {i, 2'b00}, d, 4'h1, 8'h00, RESP_OKAY);
    endtask : put

    task automatic get(input logic [6:0] i, input logic [7:0] ed);
        xfer(1'b1, {i, 2'b00}, 8'h00, 4'hf, ed, RESP_OKAY);
    endtask : get

    always @(posedge clk) begin
        if (!rst && waitreq === 1'b0 && (rd || wr)) begin
            note = notes.pop_front();
            chk(32'(note[1:0]), 32'(resp));
            if (note[10])
                chk(32'(note[9:2]), rdata);
        end
    end

    // hang guard, well above the roughly 180 cycles used
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        {rst, rd, wr, load, rng_a, rng_b, single} = 7'b1000000;
        addr = 9'h000;
        wdata = 32'h0;
        be = 4'h0;
        pwr = DBS_PWR_NORMAL;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (sp[i]) get(sp[i], RST_SETPOINT);
        foreach (oth[i]) get(oth[i], 8'h00);
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            load <= 1'b1;
            rng_a <= !r[0];
            rng_b <= r[0];
            @(posedge clk);
            load <= 1'b0;
            foreach (sp[i]) begin
                code[i] = 8'($random(seed));
                // keep clear of the reserved codes when the range bit is set
                if (code[i][5:0] > 6'h32)
                    code[i][5] = 1'b0;
                put(sp[i], code[i]);
                get(sp[i], {1'b0, (i < 3) ^ r[0], code[i][5:0]});
            end
            for (int p = 0; p < 3; p++) begin
                @(posedge clk);
                pwr <= dbs_pwr_e'(p);
                single <= r[0];
                repeat (3) @(posedge clk);
                chk(32'(lvl_a), 32'({!r[0], code[p][5:0]}));
                // combined: b takes a's code and a's range, and that range is zero here
                chk(32'(lvl_b), 32'(code[r[0] ? p : p+3][5:0]));
            end
        end
        single <= 1'b0;
        put(IDX_A_MODE, 8'hff);
        get(IDX_A_MODE, MODE_WR_MASK);
        put(IDX_B_MODE, 8'hd0);
        get(IDX_B_MODE, 8'h00);
        cfg = 8'($random(seed));
        put(IDX_B_CONFIG, cfg);
        xfer(1'b0, {IDX_B_CONFIG, 2'b00}, ~cfg, 4'he, 8'h00,
             RESP_OKAY);
        get(IDX_B_CONFIG, cfg);
        get(IDX_STATUS, 8'(DBS_PWR_SLEEP) | 8'h10);
        chk(32'(mode_a), 32'h0000000f);
        chk(32'(ramp_b), 32'(cfg[7:6]));
        chk(32'({mode_b, pfm_a, pfm_b}), 32'h00000002);
        chk(32'({current_limit_select_b, freq_b, ph_b}),
            32'({cfg[0], cfg[3:2], cfg[5:4]}));
        chk(32'({current_limit_select_a, freq_a, ph_a, ramp_a}), 32'h00000000);
        @(posedge clk);
        single <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({mode_b, pfm_b, ramp_b}), 32'h0000007c);
        xfer(1'b1, {7'h41, 2'b00}, 8'h00, 4'hf, 8'h00, RESP_SLVERR);
        xfer(1'b0, {IDX_A_NORMAL, 2'b01}, 8'h3f, 4'h1, 8'h00,
             RESP_SLVERR);
        get(IDX_A_NORMAL, {2'b00, code[0][5:0]});
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule : tb
`default_nettype wire
